// ==== rtl/oad_top.sv ====
// Purpose: Operand address decoder between prefetch queue and execution.
// Assumes: Opcode stage hands over the basic instruction and its traits.
// Notes:   Extension bytes are pulled one per cycle from the queue.
`timescale 1ns/100ps
`default_nettype none

// ***********************************************
// Mode decoder body
// ***********************************************
module oad_mode_core (
  input  wire logic [4:0]               mode,
  input  wire logic                     written,
  input  wire logic                     aux_regs,
  input  wire logic                     stack_select,
  output oad_pkg::oad_mode_info_t       info
);
  oad_pkg::oad_base_t sp_base;

  always_comb begin
    sp_base      = stack_select ? oad_pkg::OAD_B_SP1 : oad_pkg::OAD_B_SP0;
    info         = '0;
    info.kind    = oad_pkg::OAD_K_NONE;
    info.base    = oad_pkg::OAD_B_NONE;
    info.reg_sel = mode[2:0];
    case (mode[4:3])
      2'h0: begin
        info.kind = aux_regs ? oad_pkg::OAD_K_AUX : oad_pkg::OAD_K_REG;
      end
      2'h1: begin
        info.kind   = oad_pkg::OAD_K_MEM;
        info.base   = oad_pkg::OAD_B_GREG;
        info.n_disp = 2'h1;
      end
      2'h2: begin
        case (mode)
          oad_pkg::OAD_MODE_RESERVED: info.reserved = 1'b1;
          oad_pkg::OAD_MODE_IMM: begin
            info.kind   = oad_pkg::OAD_K_IMM;
            info.is_imm = 1'b1;
          end
          oad_pkg::OAD_MODE_ABS: begin
            info.kind   = oad_pkg::OAD_K_MEM;
            info.n_disp = 2'h1;
          end
          oad_pkg::OAD_MODE_LINK: begin
            info.kind   = oad_pkg::OAD_K_LINK;
            info.n_disp = 2'h2;
          end
          oad_pkg::OAD_MODE_TOS: begin
            info.kind = oad_pkg::OAD_K_TOS;
            info.base = sp_base;
            info.push = written;
          end
          default: begin
            info.kind   = oad_pkg::OAD_K_PTR;
            info.n_disp = 2'h2;
            case (mode[1:0])
              2'h0:    info.base = oad_pkg::OAD_B_FP;
              2'h1:    info.base = sp_base;
              default: info.base = oad_pkg::OAD_B_SB;
            endcase
          end
        endcase
      end
      default: begin
        if (mode[2]) begin
          info.is_index = 1'b1;
        end else begin
          info.kind   = oad_pkg::OAD_K_MEM;
          info.n_disp = 2'h1;
          case (mode[1:0])
            2'h0:    info.base = oad_pkg::OAD_B_FP;
            2'h1:    info.base = sp_base;
            2'h2:    info.base = oad_pkg::OAD_B_SB;
            default: info.base = oad_pkg::OAD_B_PC;
          endcase
        end
      end
    endcase
  end
endmodule : oad_mode_core

// ***********************************************
// Top
// ***********************************************
module oad_top (
  input  wire logic                 sys_clk,
  input  wire logic                 rst_n,
  input  wire logic                 start,
  input  wire oad_pkg::oad_inst_t   inst,
  input  wire logic                 stack_select,
  input  wire logic                 q_valid,
  input  wire logic [7:0]           q_byte,
  output logic                      q_ready,
  output logic                      busy,
  output oad_pkg::oad_result_t      result
);
  typedef enum logic [2:0] {OAD_S_IDLE, OAD_S_SEEK, OAD_S_IDXB, OAD_S_DISPF,
                            OAD_S_DISPR, OAD_S_IMMB, OAD_S_DONE} oad_st_t;

  typedef struct packed {
    oad_st_t              st;
    logic [2:0]           ph;
    logic                 op;
    logic                 item;
    logic [3:0]           cnt;
    logic [3:0]           dlen;
    logic [63:0]          acc;
    oad_pkg::oad_inst_t   inst;
    logic [1:0][4:0]      gen;
    logic [1:0][4:0]      base_mode;
    logic [1:0]           imm_left;
    logic                 dsp_left;
    logic                 busy;
    logic                 ready;
    oad_pkg::oad_result_t res;
  } oad_state_t;

  oad_state_t                        s_q;
  oad_state_t                        s_d;
  oad_pkg::oad_mode_info_t [1:0]     mi;
  logic [1:0][4:0]                   eff;
  logic [3:0]                        first_len;
  logic [31:0]                       disp_val;
  logic [63:0]                       shifted;
  logic                              take;

  // ***********************************************
  // Helpers
  // ***********************************************
  function automatic logic is_index_mode(input logic [4:0] m);
    is_index_mode = (m[4:2] == oad_pkg::OAD_MODE_IDX_TOP);
  endfunction : is_index_mode

  function automatic logic [3:0] imm_bytes(input oad_pkg::oad_inst_t i);
    if (i.is_float) begin
      imm_bytes = i.float_long ? oad_pkg::OAD_BYTES_8 : oad_pkg::OAD_BYTES_4;
    end else begin
      case (i.int_len)
        oad_pkg::OAD_LEN_BYTE: imm_bytes = oad_pkg::OAD_BYTES_1;
        oad_pkg::OAD_LEN_WORD: imm_bytes = oad_pkg::OAD_BYTES_2;
        default:               imm_bytes = oad_pkg::OAD_BYTES_4;
      endcase
    end
  endfunction : imm_bytes

  function automatic logic [31:0] sext_quick(input logic [3:0] v, input logic [1:0] len);
    case (len)
      oad_pkg::OAD_LEN_BYTE: sext_quick = {24'h00_0000, {4{v[3]}}, v};
      oad_pkg::OAD_LEN_WORD: sext_quick = {16'h0000, {12{v[3]}}, v};
      default:               sext_quick = {{28{v[3]}}, v};
    endcase
  endfunction : sext_quick

  // ***********************************************
  // Mode and displacement decoders
  // ***********************************************
  for (genvar k = 0; k < 2; k++) begin : g_mode
    assign eff[k] = is_index_mode(s_q.gen[k]) ? s_q.base_mode[k] : s_q.gen[k];
    oad_mode_decode u_mode (
      .mode         (eff[k]),
      .written      (s_q.inst.written[k]),
      .aux_regs     (s_q.inst.aux_regs),
      .stack_select (stack_select),
      .info         (mi[k])
    );
  end

  oad_disp_decode u_disp (
    .first_byte (q_byte),
    .raw        (shifted[31:0]),
    .nbytes     ((s_q.st == OAD_S_DISPF) ? first_len : s_q.dlen),
    .first_len  (first_len),
    .value      (disp_val)
  );

  assign shifted = {s_q.acc[55:0], q_byte};
  assign take    = q_valid && s_q.ready;

  // ***********************************************
  // Parser
  // ***********************************************
  always_comb begin
    logic [23:0] al;
    logic        bad;
    al            = '0;
    bad           = 1'b0;
    s_d           = s_q;
    s_d.res.valid = 1'b0;
    case (s_q.st)
      OAD_S_IDLE: begin
        if (start) begin
          case (inst.basic_len)
            2'h1:    al = {inst.basic[7:0], 16'h0000};
            2'h2:    al = {inst.basic[15:0], 8'h00};
            default: al = inst.basic;
          endcase
          s_d.inst     = inst;
          s_d.gen[0]   = al[23:19];
          s_d.gen[1]   = al[18:14];
          s_d.res      = '0;
          s_d.ph       = oad_pkg::OAD_PH_IDX0;
          s_d.item     = 1'b0;
          s_d.imm_left = inst.imp_imm_count;
          s_d.dsp_left = inst.imp_disp;
          s_d.busy     = 1'b1;
          s_d.st       = OAD_S_SEEK;
          if (inst.short_en && inst.short_is_cond) begin
            s_d.res.cond = al[18:15];
          end else if (inst.short_en) begin
            s_d.res.quick_value = sext_quick(al[18:15], inst.int_len);
          end
        end
      end
      OAD_S_SEEK: begin
        case (s_q.ph)
          oad_pkg::OAD_PH_IDX0, oad_pkg::OAD_PH_IDX1: begin
            if (s_q.inst.gen_count > {1'b0, s_q.ph[0]} && is_index_mode(s_q.gen[s_q.ph[0]])) begin
              s_d.op = s_q.ph[0];
              s_d.st = OAD_S_IDXB;
            end else begin
              s_d.ph = s_q.ph + 3'h1;
            end
          end
          oad_pkg::OAD_PH_EXT0, oad_pkg::OAD_PH_EXT1: begin
            s_d.op = s_q.ph[0];
            if (s_q.inst.gen_count > {1'b0, s_q.ph[0]} && mi[s_q.ph[0]].is_imm &&
                !s_q.item) begin
              s_d.cnt = imm_bytes(s_q.inst);
              s_d.acc = '0;
              s_d.st  = OAD_S_IMMB;
            end else if (s_q.inst.gen_count > {1'b0, s_q.ph[0]} &&
                         {1'b0, s_q.item} < mi[s_q.ph[0]].n_disp) begin
              s_d.st = OAD_S_DISPF;
            end else begin
              s_d.item = 1'b0;
              s_d.ph   = s_q.ph + 3'h1;
            end
          end
          oad_pkg::OAD_PH_IMPI: begin
            if (s_q.imm_left != 2'h0) begin
              s_d.cnt = oad_pkg::OAD_BYTES_1;
              s_d.st  = OAD_S_IMMB;
            end else begin
              s_d.ph = oad_pkg::OAD_PH_IMPD;
            end
          end
          default: begin
            s_d.st = s_q.dsp_left ? OAD_S_DISPF : OAD_S_DONE;
          end
        endcase
      end
      OAD_S_IDXB: begin
        if (take) begin
          s_d.base_mode[s_q.op]        = q_byte[7:oad_pkg::OAD_IDX_MODE_LSB];
          s_d.res.opnd[s_q.op].idx_reg = q_byte[oad_pkg::OAD_IDX_MODE_LSB-1:0];
          s_d.ph                       = s_q.op ? oad_pkg::OAD_PH_EXT0 : oad_pkg::OAD_PH_IDX1;
          s_d.st                       = OAD_S_SEEK;
        end
      end
      OAD_S_DISPF, OAD_S_DISPR: begin
        if (take) begin
          s_d.acc = shifted;
          if (s_q.st == OAD_S_DISPF) begin
            s_d.dlen = first_len;
            s_d.cnt  = first_len - 4'h1;
          end else begin
            s_d.cnt = s_q.cnt - 4'h1;
          end
          s_d.st = OAD_S_DISPR;
          if ((s_q.st == OAD_S_DISPF) ? (first_len == oad_pkg::OAD_BYTES_1)
                                      : (s_q.cnt == 4'h1)) begin
            s_d.st = OAD_S_SEEK;
            if (s_q.ph == oad_pkg::OAD_PH_IMPD) begin
              s_d.res.impl_disp = disp_val;
              s_d.dsp_left      = 1'b0;
            end else if (!s_q.item) begin
              s_d.res.opnd[s_q.op].disp1 = disp_val;
              s_d.item                   = 1'b1;
            end else begin
              s_d.res.opnd[s_q.op].disp2 = disp_val;
              s_d.item                   = 1'b0;
              s_d.ph                     = s_q.ph + 3'h1;
            end
          end
        end
      end
      OAD_S_IMMB: begin
        if (take) begin
          s_d.acc = shifted;
          s_d.cnt = s_q.cnt - 4'h1;
          if (s_q.cnt == 4'h1) begin
            s_d.st = OAD_S_SEEK;
            if (s_q.ph == oad_pkg::OAD_PH_IMPI) begin
              s_d.res.impl_imm = {s_q.res.impl_imm[0], q_byte};
              s_d.imm_left     = s_q.imm_left - 2'h1;
            end else begin
              s_d.res.opnd[s_q.op].imm = shifted;
              s_d.item                 = 1'b1;
            end
          end
        end
      end
      OAD_S_DONE: begin
        for (int k = 0; k < 2; k++) begin
          if (s_q.inst.gen_count > k[1:0]) begin
            s_d.res.opnd[k].info      = mi[k];
            s_d.res.opnd[k].idx_en    = is_index_mode(s_q.gen[k]);
            s_d.res.opnd[k].idx_shift = s_q.gen[k][1:0];
            if (mi[k].reserved || (mi[k].is_imm && s_q.inst.written[k])) begin
              bad = 1'b1;
            end
            if (is_index_mode(s_q.gen[k]) && (mi[k].is_imm || mi[k].is_index)) begin
              bad = 1'b1;
            end
          end
        end
        s_d.res.illegal = bad;
        s_d.res.valid   = 1'b1;
        s_d.busy        = 1'b0;
        s_d.st          = OAD_S_IDLE;
      end
      default: s_d.st = OAD_S_IDLE;
    endcase
    s_d.ready = (s_d.st == OAD_S_IDXB) || (s_d.st == OAD_S_DISPF) ||
                (s_d.st == OAD_S_DISPR) || (s_d.st == OAD_S_IMMB);
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q    <= '0;
      s_q.st <= OAD_S_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign q_ready = s_q.ready;
  assign busy    = s_q.busy;
  assign result  = s_q.res;
endmodule : oad_top
`default_nettype wire

// ==== rtl/oad_pkg.sv ====
// Purpose: Shared constants and types of the operand address decoder.
// Assumes: One processor clock; extension bytes arrive one per cycle.
// Notes:   Mode codes, field positions and lengths live here only.
package oad_pkg;

  // ***********************************************
  // Mode codes and field positions
  // ***********************************************
  localparam logic [4:0] OAD_MODE_RESERVED = 5'h13;
  localparam logic [4:0] OAD_MODE_IMM      = 5'h14;
  localparam logic [4:0] OAD_MODE_ABS      = 5'h15;
  localparam logic [4:0] OAD_MODE_LINK     = 5'h16;
  localparam logic [4:0] OAD_MODE_TOS      = 5'h17;
  localparam logic [2:0] OAD_MODE_IDX_TOP  = 3'h7;
  localparam int         OAD_IDX_MODE_LSB  = 3;

  // ***********************************************
  // Lengths
  // ***********************************************
  localparam logic [1:0] OAD_LEN_BYTE      = 2'h0;
  localparam logic [1:0] OAD_LEN_WORD      = 2'h1;
  localparam logic [1:0] OAD_LEN_DWORD     = 2'h3;
  localparam logic [3:0] OAD_BYTES_1       = 4'h1;
  localparam logic [3:0] OAD_BYTES_2       = 4'h2;
  localparam logic [3:0] OAD_BYTES_4       = 4'h4;
  localparam logic [3:0] OAD_BYTES_8       = 4'h8;

  // ***********************************************
  // Parse phases
  // ***********************************************
  localparam logic [2:0] OAD_PH_IDX0       = 3'h0;
  localparam logic [2:0] OAD_PH_IDX1       = 3'h1;
  localparam logic [2:0] OAD_PH_EXT0       = 3'h2;
  localparam logic [2:0] OAD_PH_EXT1       = 3'h3;
  localparam logic [2:0] OAD_PH_IMPI       = 3'h4;
  localparam logic [2:0] OAD_PH_IMPD       = 3'h5;

  // ***********************************************
  // Types
  // ***********************************************
  typedef enum logic [2:0] {OAD_K_NONE, OAD_K_REG, OAD_K_AUX, OAD_K_MEM, OAD_K_PTR,
                            OAD_K_LINK, OAD_K_IMM, OAD_K_TOS} oad_kind_t;
  typedef enum logic [2:0] {OAD_B_NONE, OAD_B_GREG, OAD_B_FP, OAD_B_SP0, OAD_B_SP1,
                            OAD_B_SB, OAD_B_PC} oad_base_t;

  typedef struct packed {
    logic [23:0] basic;
    logic [1:0]  basic_len;
    logic [1:0]  gen_count;
    logic [1:0]  written;
    logic        aux_regs;
    logic        short_en;
    logic        short_is_cond;
    logic [1:0]  int_len;
    logic        is_float;
    logic        float_long;
    logic [1:0]  imp_imm_count;
    logic        imp_disp;
  } oad_inst_t;

  typedef struct packed {
    oad_kind_t  kind;
    oad_base_t  base;
    logic [2:0] reg_sel;
    logic [1:0] n_disp;
    logic       reserved;
    logic       is_imm;
    logic       is_index;
    logic       push;
  } oad_mode_info_t;

  typedef struct packed {
    oad_mode_info_t info;
    logic           idx_en;
    logic [2:0]     idx_reg;
    logic [1:0]     idx_shift;
    logic [31:0]    disp1;
    logic [31:0]    disp2;
    logic [63:0]    imm;
  } oad_opnd_t;

  typedef struct packed {
    logic                 valid;
    logic                 illegal;
    oad_opnd_t [1:0]      opnd;
    logic [31:0]          quick_value;
    logic [3:0]           cond;
    logic [1:0][7:0]      impl_imm;
    logic [31:0]          impl_disp;
  } oad_result_t;

endpackage : oad_pkg

// ==== rtl/oad_mode_decode.sv ====
// Purpose: Turns one 5-bit mode code into an address calculation.
// Assumes: Purely combinational.
// Notes:   Scaled index codes report only the index class.
`timescale 1ns/100ps
`default_nettype none
module oad_mode_decode (
  input  wire logic [4:0]              mode,
  input  wire logic                    written,
  input  wire logic                    aux_regs,
  input  wire logic                    stack_select,
  output oad_pkg::oad_mode_info_t      info
);
  oad_mode_core u_core (
    .mode         (mode),
    .written      (written),
    .aux_regs     (aux_regs),
    .stack_select (stack_select),
    .info         (info)
  );
endmodule : oad_mode_decode
`default_nettype wire

// ==== rtl/oad_disp_decode.sv ====
// Purpose: Displacement length and sign extension.
// Assumes: Raw bytes assembled most significant first.
// Notes:   Purely combinational.
`timescale 1ns/100ps
`default_nettype none
module oad_disp_decode (
  input  wire logic [7:0]  first_byte,
  input  wire logic [31:0] raw,
  input  wire logic [3:0]  nbytes,
  output logic      [3:0]  first_len,
  output logic      [31:0] value
);
  always_comb begin
    if (!first_byte[7]) begin
      first_len = oad_pkg::OAD_BYTES_1;
    end else if (!first_byte[6]) begin
      first_len = oad_pkg::OAD_BYTES_2;
    end else begin
      first_len = oad_pkg::OAD_BYTES_4;
    end
    case (nbytes)
      oad_pkg::OAD_BYTES_1: value = {{25{raw[6]}}, raw[6:0]};
      oad_pkg::OAD_BYTES_2: value = {{18{raw[13]}}, raw[13:0]};
      default:              value = {{2{raw[29]}}, raw[29:0]};
    endcase
  end
endmodule : oad_disp_decode
`default_nettype wire

// ==== testbench/oad_props.sv ====
// Purpose: Port assertions of the operand address decoder.
// Assumes: Bound into oad_top.
// Notes:   No extension bytes gives a result 8 edges after start.
`timescale 1ns/100ps
`default_nettype none
module oad_props (
  input wire logic                 sys_clk,
  input wire logic                 rst_n,
  input wire logic                 start,
  input wire oad_pkg::oad_inst_t   inst,
  input wire logic                 stack_select,
  input wire logic                 q_valid,
  input wire logic [7:0]           q_byte,
  input wire logic                 q_ready,
  input wire logic                 busy,
  input wire oad_pkg::oad_result_t result
);
  // ****************
  // Properties
  // ****************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic go;
  logic plain;
  assign go = start && !busy;
  assign plain = inst.gen_count == 2'h1 && inst.imp_imm_count == 2'h0 && !inst.imp_disp
                 && inst.basic_len == 2'h3;
  property p_busy_go;
    go |=> busy;
  endproperty
  a_busy_go: assert property (p_busy_go) else $error("busy not raised");
  property p_pulse;
    result.valid |=> !result.valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid too long");
  property p_idle;
    result.valid |-> !busy && $past(busy);
  endproperty
  a_idle: assert property (p_idle) else $error("valid without busy end");
  property p_ready;
    q_ready |-> busy;
  endproperty
  a_ready: assert property (p_ready) else $error("ready while idle");
  property p_plain_time;
    go ##1 !q_ready [*7] |=> result.valid;
  endproperty
  a_plain_time: assert property (p_plain_time) else $error("late result");
  property p_reserved;
    go && plain && inst.basic[23:19] == oad_pkg::OAD_MODE_RESERVED
      |-> ##8 result.valid && result.illegal;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not flagged");
  property p_reg;
    logic [2:0] r;
    (go && plain && inst.basic[23:22] == 2'h0, r = inst.basic[21:19])
      |-> ##8 result.valid && result.opnd[0].info.reg_sel == r;
  endproperty
  a_reg: assert property (p_reg) else $error("register select wrong");
  property p_quick;
    logic [3:0] s;
    (go && plain && inst.short_en && !inst.short_is_cond && inst.basic[23:22] == 2'h0
      && inst.int_len == oad_pkg::OAD_LEN_DWORD, s = inst.basic[18:15])
      |-> ##8 result.valid && result.quick_value == {{28{s[3]}}, s};
  endproperty
  a_quick: assert property (p_quick) else $error("quick value wrong");
  property p_reset;
    $rose(rst_n) |-> !busy && !q_ready && !result.valid;
  endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear");
endmodule : oad_props
bind oad_top oad_props i_props (.sys_clk(sys_clk), .rst_n(rst_n), .start(start),
  .inst(inst), .stack_select(stack_select), .q_valid(q_valid), .q_byte(q_byte),
  .q_ready(q_ready), .busy(busy), .result(result));
`default_nettype wire

// ==== testbench/oad_queue_model.sv ====
// Purpose: Prefetch queue model offering extension bytes.
// Assumes: Bench loads bytes through put.
// Notes:   Idle byte lane inverts its own value every cycle.
`timescale 1ns/100ps
`default_nettype none
module oad_queue_model (
  input  wire logic       sys_clk,
  input  wire logic       stall_en,
  input  wire logic       q_ready,
  output var  logic       q_valid,
  output var  logic [7:0] q_byte
);
  // ****************
  // Byte offer
  // ****************
  logic [7:0]  fifo[$];
  logic [31:0] lfsr = 32'h4570;
  logic        taken;
  initial begin
    q_valid = 1'b0;
    q_byte  = 8'h00;
  end
  task automatic put(input logic [7:0] b);
    fifo.push_back(b);
  endtask : put
  always @(posedge sys_clk) begin
    taken = q_valid && q_ready;
    if (taken) void'(fifo.pop_front());
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    #1;
    // Offer held until taken
    if (taken || !q_valid) begin
      q_valid = fifo.size() > 0 && !(stall_en && lfsr[0]);
      q_byte  = q_valid ? fifo[0] : ~q_byte;
    end
  end
endmodule : oad_queue_model
`default_nettype wire

// ==== testbench/operand_address_decoder_bench.sv ====
// Purpose: Self-checking bench of the operand address decoder.
// Assumes: Queue model hands out extension bytes in order.
// Notes:   Random values from a fixed-seed shift register.
`timescale 1ns/100ps
`default_nettype none
module operand_address_decoder_bench;
  // ****************
  // Bench
  // ****************
  logic                 sys_clk = 1'b0;
  logic                 rst_n = 1'b0;
  logic                 start = 1'b0;
  logic                 stack_select = 1'b0;
  logic                 stall_en = 1'b0;
  logic                 q_valid;
  logic                 q_ready;
  logic                 busy;
  logic [7:0]           q_byte;
  oad_pkg::oad_inst_t   ins = '0;
  oad_pkg::oad_result_t result;
  oad_pkg::oad_result_t res;
  logic [31:0]          rnd = 32'h4570;
  logic [63:0]          v;
  logic [31:0]          e1;
  logic [31:0]          e2;
  logic [4:0]           m;
  logic [3:0]           s;
  int                   n;
  int                   fails = 0;
  int                   num_checks = 0;
  int                   cyc = 0;
  oad_top i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .start(start), .inst(ins),
    .stack_select(stack_select), .q_valid(q_valid), .q_byte(q_byte),
    .q_ready(q_ready), .busy(busy), .result(result));
  oad_queue_model i_q (.sys_clk(sys_clk), .stall_en(stall_en), .q_ready(q_ready),
    .q_valid(q_valid), .q_byte(q_byte));
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 5000) begin
      fails++;
      wrap_up();
    end
  end
  function automatic logic [31:0] lf(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lf
  function automatic int nb(input int i);
    return i % 3 == 0 ? 1 : i % 3 == 1 ? 2 : 4;
  endfunction : nb
  function automatic oad_pkg::oad_base_t base_of(input logic [4:0] md, input logic sel);
    if (md[4:3] == 2'h1) return oad_pkg::OAD_B_GREG;
    if (md == oad_pkg::OAD_MODE_ABS || md == oad_pkg::OAD_MODE_LINK) return oad_pkg::OAD_B_NONE;
    case (md[1:0])
      2'h0: return oad_pkg::OAD_B_FP;
      2'h1: return sel ? oad_pkg::OAD_B_SP1 : oad_pkg::OAD_B_SP0;
      2'h2: return oad_pkg::OAD_B_SB;
      default: return oad_pkg::OAD_B_PC;
    endcase
  endfunction : base_of
  task automatic wrap_up();
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Bytes go out most significant first
  task automatic put(input logic [63:0] w, input int cnt);
    for (int i = cnt - 1; i >= 0; i--) i_q.put(w[8*i +: 8]);
  endtask : put
  task automatic disp(input int cnt, output logic [31:0] e);
    rnd = lf(rnd);
    e = cnt == 1 ? {{25{rnd[6]}}, rnd[6:0]} : cnt == 2 ? {{18{rnd[13]}}, rnd[13:0]}
      : {{2{rnd[29]}}, rnd[29:0]};
    put(cnt == 1 ? {57'h0, rnd[6:0]} : cnt == 2 ? {48'h0, 2'h2, rnd[13:0]}
      : {32'h0, 2'h3, rnd[29:0]}, cnt);
  endtask : disp
  task automatic run(input logic [4:0] g0, input logic [4:0] g1);
    ins.basic = {g0, g1, 14'h0};
    start = 1'b1;
    @(posedge sys_clk);
    #1;
    start = 1'b0;
    for (int k = 0; k < 300 && result.valid !== 1'b1; k++) begin
      @(posedge sys_clk);
      #1;
    end
    res = result;
    chk(result.valid, 1'b1);
    chk(i_q.fifo.size(), 0);
  endtask : run
  initial begin
    ins.basic_len = 2'h3;
    ins.gen_count = 2'h1;
    repeat (2) @(posedge sys_clk);
    #1;
    rst_n = 1'b1;
    for (int i = 0; i < 16; i++) begin
      ins.aux_regs = i[3];
      run({2'h0, i[2:0]}, 5'h00);
      chk(res.opnd[0].info.kind, i[3] ? oad_pkg::OAD_K_AUX : oad_pkg::OAD_K_REG);
    end
    ins.aux_regs = 1'b0;
    stall_en = 1'b1;
    for (int i = 0; i < 13; i++) begin
      m = i < 8 ? 5'h08 + i[4:0] : i < 12 ? 5'h10 + i[4:0] : oad_pkg::OAD_MODE_ABS;
      stack_select = i[0];
      disp(nb(i), e1);
      run(m, 5'h00);
      chk(res.opnd[0].disp1, e1);
      chk(res.opnd[0].info.kind, oad_pkg::OAD_K_MEM);
      chk(res.opnd[0].info.base, base_of(m, i[0]));
      if (i < 8) chk(res.opnd[0].info.reg_sel, i[2:0]);
    end
    for (int i = 0; i < 4; i++) begin
      m = i < 3 ? 5'h10 + i[4:0] : oad_pkg::OAD_MODE_LINK;
      stack_select = ~i[0];
      disp(nb(i + 2), e1);
      disp(nb(i), e2);
      run(m, 5'h00);
      chk(res.opnd[0].disp1, e1);
      chk(res.opnd[0].disp2, e2);
      chk(res.opnd[0].info.kind, i < 3 ? oad_pkg::OAD_K_PTR : oad_pkg::OAD_K_LINK);
      chk(res.opnd[0].info.base, base_of(m, ~i[0]));
    end
    run(oad_pkg::OAD_MODE_RESERVED, 5'h00);
    chk(res.illegal, 1'b1);
    for (int i = 0; i < 2; i++) begin
      ins.written = {1'b0, i[0]};
      run(oad_pkg::OAD_MODE_TOS, 5'h00);
      chk({res.opnd[0].info.kind, res.opnd[0].info.push}, {oad_pkg::OAD_K_TOS, i[0]});
    end
    for (int i = 0; i < 6; i++) begin
      ins.int_len = i == 1 ? oad_pkg::OAD_LEN_WORD : i == 2 ? oad_pkg::OAD_LEN_DWORD : 2'h0;
      ins.is_float = i == 3 || i == 4;
      ins.float_long = i == 4;
      ins.written = {1'b0, i == 5};
      n = i == 1 ? 2 : i == 2 || i == 3 ? 4 : i == 4 ? 8 : 1;
      v = {lf(rnd), rnd};
      rnd = lf(lf(rnd));
      put(v, n);
      run(oad_pkg::OAD_MODE_IMM, 5'h00);
      chk(res.opnd[0].imm, n == 8 ? v : v & ((64'h1 << (8 * n)) - 64'h1));
      chk(res.illegal, i == 5);
    end
    ins = '{basic_len: 2'h3, gen_count: 2'h2, default: '0};
    for (int i = 0; i < 4; i++) begin
      rnd = lf(rnd);
      s = rnd[11:8];
      v = {32'h0, rnd};
      i_q.put({5'h0b, rnd[2:0]});
      i_q.put({i == 3 ? oad_pkg::OAD_MODE_IMM : 5'h02, rnd[5:3]});
      disp(nb(i), e1);
      if (i == 3) put({60'h0, s}, 1);
      run(5'h1c + i[4:0], 5'h1f - i[4:0]);
      chk({res.opnd[0].idx_en, res.opnd[0].idx_reg, res.opnd[1].idx_reg},
          {1'b1, v[2:0], v[5:3]});
      chk({res.opnd[0].idx_shift, res.opnd[1].idx_shift}, {i[1:0], 2'h3 - i[1:0]});
      chk({res.opnd[0].info.reg_sel, res.opnd[0].disp1}, {3'h3, e1});
      chk(res.illegal, i == 3);
    end
    ins = '{basic_len: 2'h3, gen_count: 2'h1, short_en: 1'b1, default: '0};
    for (int i = 0; i < 6; i++) begin
      rnd = lf(rnd);
      n = i % 3;
      ins.int_len = n == 0 ? 2'h0 : n == 1 ? oad_pkg::OAD_LEN_WORD : oad_pkg::OAD_LEN_DWORD;
      ins.short_is_cond = i > 2;
      s = i == 0 ? 4'h8 : rnd[3:0];
      run(5'h01, {s, 1'b0});
      if (i > 2) chk(res.cond, s);
      else chk(res.quick_value,
               {{28{s[3]}}, s} & (n == 0 ? 32'h00ff : n == 1 ? 32'hffff : '1));
    end
    ins = '{basic_len: 2'h3, gen_count: 2'h1, imp_imm_count: 2'h2, imp_disp: 1'b1, default: '0};
    disp(1, e1);
    v = {48'h0, rnd[23:8]};
    put(v, 2);
    disp(2, e2);
    run(5'h08, 5'h00);
    chk({res.opnd[0].disp1, res.impl_imm, res.impl_disp}, {e1, v[15:0], e2});
    wrap_up();
  end
endmodule : operand_address_decoder_bench
`default_nettype wire
